// ---- design/dmccs_ahb.sv ----
/*
 * AHB-Lite slave front end: turns bus transfers into a write strobe and
 * a registered read. Assumes single word transfers and zero wait states.
 */
`timescale 1ns/100ps
module dmccs_ahb (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             wr_stb,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data
);

  logic accept;

  // A transfer is taken on NONSEQ or SEQ while the bus is ready.
  assign accept = hsel & hready & htrans[1];
  assign rd_addr = haddr[7:0];
  assign wr_data = hwdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // The write lands in the data phase; read data is captured early.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_stb  <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      wr_stb <= accept & hwrite & (hsize == 3'h2);
      if (accept) begin
        wr_addr <= haddr[7:0];
      end
      if (accept & ~hwrite) begin
        hrdata <= rd_data;
      end
    end
  end

endmodule // dmccs_ahb

// ---- design/dmccs_seq.sv ----
/*
 * Device-side sequencer for DLL on/off switching and input clock
 * frequency changes. Decodes the command pins, keeps the mode registers,
 * times the delays and records misuse by the controller in sticky error
 * bits reached over AHB-Lite. Assumes command pins synchronous to sys_clk.
 */
// Function
// - Extended A0 set disables DLL; then wait.
// - Next command only after mode delay; mode writes are taken after the cycle delay.
// - Extended A0 cleared re-enables the DLL.
// - Base A8 set starts a DLL reset.
// - Clock ignored in self refresh after entry.
// - DLL-off supports only latency six.
`timescale 1ns/100ps
module dmccs_seq (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire dmccs_pkg::dmccs_cmd_t cmd,
  input  wire logic                  cke,
  input  wire logic                  term_ctrl_in,
  output logic                       dll_enabled,
  output logic                       dll_locked,
  output logic                       cmd_ready,
  output logic                       clock_ignored,
  output logic                       self_refresh,
  output logic                       power_down
);

  dmccs_pkg::dmccs_state_t state;
  logic [12:0] base_mode_reg;
  logic [12:0] extended_mode_reg;
  logic [12:0] mr2_reg;
  logic [31:0] time0;
  logic [31:0] time1;
  logic [31:0] time2;
  logic [dmccs_pkg::NUM_ERR-1:0] err;
  logic [dmccs_pkg::NUM_ERR-1:0] err_set;
  logic        cke_prev;
  logic        term_was_en;
  logic        hold_win;
  logic        relock_due;
  logic        lock_run;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic [dmccs_pkg::NUM_TMR-1:0] tmr_load;
  logic [dmccs_pkg::NUM_TMR-1:0] tmr_busy;
  logic [dmccs_pkg::TMR_W-1:0]   tmr_val [dmccs_pkg::NUM_TMR];
  logic nop_like;
  logic is_mrs;
  logic is_ref;
  logic is_long_cal;
  logic is_rw;
  logic in_idle;
  logic mrs_acc;
  logic zq_acc;
  logic dll_rst_acc;
  logic sr_entry;
  logic pd_entry;
  logic sr_exit;
  logic pd_exit;
  logic term_en_now;
  logic next_dll_off;
  logic [12:0] next_bmr;
  logic [12:0] next_mr2;

  dmccs_ahb u_ahb (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data)
  );

  // Command decode from the chip select and strobe pins.
  assign nop_like = cmd.cs_n | (cmd.ras_n & cmd.cas_n & cmd.we_n);
  assign is_mrs = ~cmd.cs_n & ~cmd.ras_n & ~cmd.cas_n & ~cmd.we_n;
  assign is_ref = ~cmd.cs_n & ~cmd.ras_n & ~cmd.cas_n & cmd.we_n;
  assign is_long_cal = ~cmd.cs_n & cmd.ras_n & cmd.cas_n & ~cmd.we_n
                   & cmd.addr[dmccs_pkg::CALIB_BIT];
  assign is_rw = ~cmd.cs_n & cmd.ras_n & ~cmd.cas_n;
  assign in_idle = (state == dmccs_pkg::ST_IDLE) & cke_prev & cke;

  // Mode writes need the cycle delay, all else the mode delay.
  assign mrs_acc = in_idle & is_mrs & ~tmr_busy[dmccs_pkg::TMR_MRD];
  assign zq_acc = in_idle & is_long_cal
                  & ~tmr_busy[dmccs_pkg::TMR_MOD];
  assign dll_rst_acc = mrs_acc & (cmd.ba == dmccs_pkg::BA_BMR)
                       & cmd.addr[dmccs_pkg::BMR_DLL_RST]
                       & dll_enabled;
  assign sr_entry = (state == dmccs_pkg::ST_IDLE) & cke_prev & ~cke
                    & is_ref;
  assign pd_entry = (state == dmccs_pkg::ST_IDLE) & cke_prev & ~cke
                    & nop_like;
  assign sr_exit = (state == dmccs_pkg::ST_SREF) & cke;
  assign pd_exit = (state == dmccs_pkg::ST_PDN) & cke;

  // Any termination feature currently programmed.
  assign term_en_now = extended_mode_reg[dmccs_pkg::EMR_RTT_A]
                       | extended_mode_reg[dmccs_pkg::EMR_RTT_B]
                       | extended_mode_reg[dmccs_pkg::EMR_RTT_C]
                       | mr2_reg[dmccs_pkg::MR2_RTTW_A]
                       | mr2_reg[dmccs_pkg::MR2_RTTW_B];

  // Timer loads, each from its programmable cycle count.
  assign tmr_load[dmccs_pkg::TMR_MOD] = mrs_acc;
  assign tmr_load[dmccs_pkg::TMR_MRD] = mrs_acc;
  assign tmr_load[dmccs_pkg::TMR_ENTRY] = sr_entry | pd_entry;
  assign tmr_load[dmccs_pkg::TMR_EXIT] = sr_exit | pd_exit;
  assign tmr_load[dmccs_pkg::TMR_LOCK] = dll_rst_acc;
  assign tmr_load[dmccs_pkg::TMR_CAL] = zq_acc;
  assign tmr_val[dmccs_pkg::TMR_MOD] =
    {4'h0, time0[dmccs_pkg::F_MOD +: 8]};
  assign tmr_val[dmccs_pkg::TMR_MRD] = {4'h0, time0[dmccs_pkg::F_MRD +: 8]};
  assign tmr_val[dmccs_pkg::TMR_ENTRY] =
    {4'h0, time0[dmccs_pkg::F_CKSRE +: 8]};
  assign tmr_val[dmccs_pkg::TMR_EXIT] = sr_exit ?
    time1[dmccs_pkg::F_XS +: dmccs_pkg::TMR_W] :
    {4'h0, time0[dmccs_pkg::F_XP +: 8]};
  assign tmr_val[dmccs_pkg::TMR_LOCK] =
    time1[dmccs_pkg::F_LOCK +: dmccs_pkg::TMR_W];
  assign tmr_val[dmccs_pkg::TMR_CAL] =
    time2[dmccs_pkg::F_CAL +: dmccs_pkg::TMR_W];

  // One delay timer per tracked delay, except that the XS and XP exit delays share the exit timer.
  genvar gi;
  generate
    for (gi = 0; gi < dmccs_pkg::NUM_TMR; gi++) begin : g_tmr
      dmccs_timer u_tmr (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .load     (tmr_load[gi]),
        .load_val (tmr_val[gi]),
        .busy     (tmr_busy[gi])
      );
    end
  endgenerate

  // Power state: self refresh, precharge power-down and their exits.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= dmccs_pkg::ST_IDLE;
    end else begin
      unique case (state)
        dmccs_pkg::ST_IDLE: begin
          if (sr_entry) begin
            state <= dmccs_pkg::ST_SREF;
          end else if (pd_entry) begin
            state <= dmccs_pkg::ST_PDN;
          end
        end
        dmccs_pkg::ST_SREF: begin
          if (cke) begin
            state <= dmccs_pkg::ST_SR_EXIT;
          end
        end
        dmccs_pkg::ST_PDN: begin
          if (cke) begin
            state <= dmccs_pkg::ST_PD_EXIT;
          end
        end
        dmccs_pkg::ST_SR_EXIT, dmccs_pkg::ST_PD_EXIT: begin
          if (~tmr_busy[dmccs_pkg::TMR_EXIT]
              & ~tmr_load[dmccs_pkg::TMR_EXIT]) begin
            state <= dmccs_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= dmccs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Clock enable history for entry edges; exits look only at the current level.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cke_prev <= 1'b0;
    end else begin
      cke_prev <= cke;
    end
  end

  // New mode register values with the write applied.
  always_comb begin
    next_bmr = base_mode_reg;
    next_mr2 = mr2_reg;
    next_dll_off = ~dll_enabled;
    if (mrs_acc && cmd.ba == dmccs_pkg::BA_BMR) begin
      next_bmr = cmd.addr;
    end
    if (mrs_acc && cmd.ba == dmccs_pkg::BA_MR2) begin
      next_mr2 = cmd.addr;
    end
    if (mrs_acc && cmd.ba == dmccs_pkg::BA_EMR) begin
      next_dll_off = cmd.addr[dmccs_pkg::EMR_DLL_OFF];
    end
  end

  // Mode registers and the DLL enable they carry.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      base_mode_reg <= dmccs_pkg::BMR_RST;
      extended_mode_reg <= dmccs_pkg::EMR_RST;
      mr2_reg <= dmccs_pkg::MR2_RST;
      dll_enabled <= 1'b1;
    end else begin
      base_mode_reg <= next_bmr;
      mr2_reg <= next_mr2;
      if (mrs_acc && cmd.ba == dmccs_pkg::BA_EMR) begin
        extended_mode_reg <= cmd.addr;
        dll_enabled <= ~cmd.addr[dmccs_pkg::EMR_DLL_OFF];
      end
    end
  end

  // Lock tracking: lost on disable, reset or relock demand.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dll_locked <= 1'b1;
      lock_run <= 1'b0;
    end else if (~dll_enabled | next_dll_off) begin
      dll_locked <= 1'b0;
      lock_run <= 1'b0;
    end else if (dll_rst_acc) begin
      dll_locked <= 1'b0;
      lock_run <= 1'b1;
    end else if (pd_exit & time2[dmccs_pkg::F_RELOCK]) begin
      dll_locked <= 1'b0;
    end else if (lock_run & ~tmr_busy[dmccs_pkg::TMR_LOCK]) begin
      dll_locked <= 1'b1;
      lock_run <= 1'b0;
    end
  end

  // Termination state at entry, and the hold window after exit.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      term_was_en <= 1'b0;
      hold_win <= 1'b0;
      relock_due <= 1'b0;
    end else begin
      if (sr_entry) begin
        term_was_en <= term_en_now;
      end else if (pd_entry) begin
        term_was_en <= extended_mode_reg[dmccs_pkg::EMR_RTT_A]
                       | extended_mode_reg[dmccs_pkg::EMR_RTT_B]
                       | extended_mode_reg[dmccs_pkg::EMR_RTT_C];
      end
      if (pd_exit & time2[dmccs_pkg::F_RELOCK]) begin
        relock_due <= 1'b1;
      end else if (dll_rst_acc) begin
        relock_due <= 1'b0;
      end
      if (sr_exit | (pd_exit & time2[dmccs_pkg::F_RELOCK])) begin
        hold_win <= 1'b1;
      end else if (state == dmccs_pkg::ST_IDLE & ~relock_due & ~lock_run
                   & ~tmr_busy[dmccs_pkg::TMR_MOD] & ~mrs_acc
                   & ~dll_rst_acc) begin
        hold_win <= 1'b0;
      end
    end
  end

  // Misuse by the controller, one sticky bit per kind.
  always_comb begin
    err_set = '0;
    err_set[dmccs_pkg::E_IDLE] = (sr_entry & (term_ctrl_in
      | tmr_busy[dmccs_pkg::TMR_MOD]))
      | (mrs_acc & (cmd.ba == dmccs_pkg::BA_EMR) & dll_enabled
      & cmd.addr[dmccs_pkg::EMR_DLL_OFF] & term_ctrl_in);
    err_set[dmccs_pkg::E_CMD] = (state == dmccs_pkg::ST_IDLE) & cke_prev
      & ~nop_like & ~mrs_acc & tmr_busy[dmccs_pkg::TMR_MOD];
    err_set[dmccs_pkg::E_CKE] = hold_win & cke_prev & ~cke;
    err_set[dmccs_pkg::E_TERM] = term_ctrl_in & term_was_en
      & (hold_win | state == dmccs_pkg::ST_PDN
      | state == dmccs_pkg::ST_SREF);
    err_set[dmccs_pkg::E_NOP] = (state == dmccs_pkg::ST_SR_EXIT)
      & ~nop_like;
    err_set[dmccs_pkg::E_LOCK] = in_idle & is_rw & (~dll_locked
      & dll_enabled | tmr_busy[dmccs_pkg::TMR_CAL]);
    err_set[dmccs_pkg::E_LAT] = mrs_acc & next_dll_off
      & ((next_bmr[dmccs_pkg::BMR_RL_LSB +: 3] != dmccs_pkg::RL_SIX)
      | (next_mr2[dmccs_pkg::MR2_WL_LSB +: 3] != dmccs_pkg::WL_SIX));
  end

  // Error bits: a new event wins over a write-one clear.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err <= '0;
    end else if (wr_stb && wr_addr == dmccs_pkg::OFS_ERROR) begin
      err <= (err & ~wr_data[dmccs_pkg::NUM_ERR-1:0]) | err_set;
    end else begin
      err <= err | err_set;
    end
  end

  // Timing count registers written by software.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      time0 <= dmccs_pkg::TIME0_RST;
      time1 <= dmccs_pkg::TIME1_RST;
      time2 <= dmccs_pkg::TIME2_RST;
    end else if (wr_stb) begin
      if (wr_addr == dmccs_pkg::OFS_TIME0) begin
        time0 <= wr_data;
      end
      if (wr_addr == dmccs_pkg::OFS_TIME1) begin
        time1 <= wr_data & 32'h0FFF0FFF;
      end
      if (wr_addr == dmccs_pkg::OFS_TIME2) begin
        time2 <= wr_data & 32'h80000FFF;
      end
    end
  end

  // Register read mux; unmapped offsets read zero.
  always_comb begin
    unique case (rd_addr)
      dmccs_pkg::OFS_STATUS: rd_data = {23'h000000, relock_due, hold_win,
        clock_ignored, cmd_ready, dll_locked, dll_enabled, state};
      dmccs_pkg::OFS_ERROR: rd_data = {25'h0000000, err};
      dmccs_pkg::OFS_TIME0: rd_data = time0;
      dmccs_pkg::OFS_TIME1: rd_data = time1;
      dmccs_pkg::OFS_TIME2: rd_data = time2;
      dmccs_pkg::OFS_MODE: rd_data = {3'h0, extended_mode_reg, 3'h0,
        base_mode_reg};
      default: rd_data = 32'h00000000;
    endcase
  end

  // Clock is a don't-care once entry delay has passed.
  assign clock_ignored = (state == dmccs_pkg::ST_SREF
    | state == dmccs_pkg::ST_PDN)
    & ~tmr_busy[dmccs_pkg::TMR_ENTRY];
  assign cmd_ready = (state == dmccs_pkg::ST_IDLE)
    & ~tmr_busy[dmccs_pkg::TMR_MOD];
  assign self_refresh = (state == dmccs_pkg::ST_SREF);
  assign power_down = (state == dmccs_pkg::ST_PDN);

endmodule // dmccs_seq

// ---- design/dmccs_timer.sv ----
/*
 * Down counter that measures one delay and reports while it runs.
 * Assumes the load value is given in clock cycles.
 */
`timescale 1ns/100ps
module dmccs_timer (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       load,
  input  wire logic [dmccs_pkg::TMR_W-1:0] load_val,
  output logic                            busy
);

  logic [dmccs_pkg::TMR_W-1:0] count;

  // A load restarts the count; otherwise it runs down to zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (load) begin
      count <= load_val;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign busy = (count != '0);

endmodule // dmccs_timer

// ---- inc/dmccs_pkg.sv ----
/*
 * Constants, types and register map of the DLL mode and clock change
 * sequencer. Assumes a 125 MHz system clock and a 32-bit AHB-Lite bus.
 */
package dmccs_pkg;

  // Clock period in picoseconds.
  localparam int unsigned CLK_PERIOD_PS = 8000;

  // Default delay times in nanoseconds, rounded up to whole cycles.
  localparam int unsigned MOD_DELAY_NS   = 96;
  localparam int unsigned MRD_DELAY_NS   = 32;
  localparam int unsigned CKSRE_DELAY_NS = 40;
  localparam int unsigned XP_DELAY_NS    = 24;
  localparam int unsigned XS_DELAY_NS    = 400;
  localparam int unsigned LOCK_TIME_NS   = 4096;
  localparam int unsigned CAL_TIME_NS    = 2048;
  localparam int unsigned MOD_CYC   =
    (MOD_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned MRD_CYC   =
    (MRD_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CKSRE_CYC =
    (CKSRE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned XP_CYC    =
    (XP_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned XS_CYC    =
    (XS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned LOCK_CYC  =
    (LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CAL_CYC   =
    (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Delay timers.
  localparam int TMR_W     = 12;
  localparam int TMR_MOD   = 0;
  localparam int TMR_MRD   = 1;
  localparam int TMR_ENTRY = 2;
  localparam int TMR_EXIT  = 3;
  localparam int TMR_LOCK  = 4;
  localparam int TMR_CAL   = 5;
  localparam int NUM_TMR   = 6;

  // Register byte offsets.
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_ERROR  = 8'h04;
  localparam logic [7:0] OFS_TIME0  = 8'h08;
  localparam logic [7:0] OFS_TIME1  = 8'h0C;
  localparam logic [7:0] OFS_TIME2  = 8'h10;
  localparam logic [7:0] OFS_MODE   = 8'h14;

  // Timing register fields: TIME0 holds four 8-bit counts.
  localparam int F_MOD   = 0;
  localparam int F_MRD   = 8;
  localparam int F_CKSRE = 16;
  localparam int F_XP    = 24;
  localparam int F_LOCK  = 0;
  localparam int F_XS    = 16;
  localparam int F_CAL   = 0;
  localparam int F_RELOCK = 31;
  localparam logic [31:0] TIME0_RST = {8'(XP_CYC), 8'(CKSRE_CYC),
                                       8'(MRD_CYC), 8'(MOD_CYC)};
  localparam logic [31:0] TIME1_RST = {4'h0, 12'(XS_CYC), 4'h0,
                                       12'(LOCK_CYC)};
  localparam logic [31:0] TIME2_RST = {20'h00000, 12'(CAL_CYC)};

  // Error bits.
  localparam int E_IDLE = 0;
  localparam int E_CMD  = 1;
  localparam int E_CKE  = 2;
  localparam int E_TERM = 3;
  localparam int E_NOP  = 4;
  localparam int E_LOCK = 5;
  localparam int E_LAT  = 6;
  localparam int NUM_ERR = 7;

  // Mode register fields.
  localparam int EMR_DLL_OFF  = 0;
  localparam int BMR_DLL_RST  = 8;
  localparam int EMR_RTT_A    = 2;
  localparam int EMR_RTT_B    = 6;
  localparam int EMR_RTT_C    = 9;
  localparam int MR2_RTTW_A   = 9;
  localparam int MR2_RTTW_B   = 10;
  localparam int BMR_RL_LSB   = 4;
  localparam int MR2_WL_LSB   = 3;
  localparam logic [2:0] RL_SIX = 3'h2;
  localparam logic [2:0] WL_SIX = 3'h1;
  localparam logic [12:0] BMR_RST = 13'h0020;
  localparam logic [12:0] EMR_RST = 13'h0000;
  localparam logic [12:0] MR2_RST = 13'h0008;
  localparam logic [2:0] BA_BMR = 3'h0;
  localparam logic [2:0] BA_EMR = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  localparam int CALIB_BIT = 10;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SREF    = 3'b001,
    ST_PDN     = 3'b010,
    ST_SR_EXIT = 3'b011,
    ST_PD_EXIT = 3'b100
  } dmccs_state_t;

  // Command pins sampled at a clock edge.
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [12:0] addr;
  } dmccs_cmd_t;

endpackage

// ---- sim/dmccs_assertions.sv ----
/* Concurrent checks on the sequencer outputs.
   Bound to dmccs_seq and sees only its ports. */
`timescale 1ns/100ps
module dmccs_chk (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire dmccs_pkg::dmccs_cmd_t cmd,
  input wire logic                  cke,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic                  dll_enabled,
  input wire logic                  dll_locked,
  input wire logic                  cmd_ready,
  input wire logic                  clock_ignored,
  input wire logic                  self_refresh,
  input wire logic                  power_down
);
  // A mode register write that the ready device takes.
  logic go;
  assign go = cmd_ready && cke && {cmd.cs_n, cmd.ras_n, cmd.cas_n,
                                   cmd.we_n} == 4'h0;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  dll_off_a: assert property (go && cmd.ba == 3'h1 && cmd.addr[0]
    |=> !dll_enabled && !dll_locked) else $error("loop not disabled");
  dll_on_a: assert property (go && cmd.ba == 3'h1 && !cmd.addr[0]
    |=> dll_enabled) else $error("loop not enabled");
  mode_gap_a: assert property (go |=> !cmd_ready [*8])
    else $error("ready too soon after mode write");
  dll_reset_a: assert property (go && cmd.ba == 3'h0 && cmd.addr[8]
    |=> !dll_locked) else $error("reset did not drop lock");
  off_unlocked_a: assert property (!dll_enabled |-> !dll_locked)
    else $error("locked while loop off");
  ignore_mode_a: assert property (clock_ignored
    |-> self_refresh || power_down) else $error("clock ignored in idle");
  ready_idle_a: assert property (cmd_ready
    |-> !self_refresh && !power_down) else $error("ready while asleep");
  cover property (go ##1 !dll_enabled);
  cover property (clock_ignored && self_refresh);
  cover property (clock_ignored && power_down);
endmodule // dmccs_chk

bind dmccs_seq dmccs_chk u_dmccs_chk (.sys_clk, .rst, .cmd, .cke,
  .hreadyout, .hresp, .dll_enabled, .dll_locked, .cmd_ready,
  .clock_ignored, .self_refresh, .power_down);

// ---- sim/dmccs_ctrl.sv ----
/* Memory controller model driving command pins and clock enable.
   Assumes the bench paces the waits between its commands. */
`timescale 1ns/100ps
module dmccs_ctrl (
  input  wire logic             sys_clk,
  output dmccs_pkg::dmccs_cmd_t cmd,
  output logic                  cke,
  output logic                  term_ctrl_in
);
  // Start idle with NOP, clock enable high and termination kept off.
  initial begin
    cmd = {4'h7, 16'h0000};
    cke = 1'b1;
    term_ctrl_in = 1'b0;
  end
  // One command on one edge, then NOP with the address lines inverted.
  task automatic op(input logic [3:0] c, input logic [2:0] b,
                    input logic [12:0] a, input logic k);
    @(posedge sys_clk);
    cmd <= {c, b, a};
    cke <= k;
    @(posedge sys_clk);
    cmd <= {4'h7, ~b, ~a};
    #1;
  endtask
endmodule // dmccs_ctrl

// ---- sim/testbench.sv ----
/* Self-checking bench for the sequencer over AHB-Lite and command pins.
   Assumes zero wait state bus and small programmed delays. */
`timescale 1ns/100ps
module testbench;
  localparam int XS = 10;
  localparam int LK = 20;
  localparam int MOD = dmccs_pkg::MOD_CYC;
  localparam int SRE = dmccs_pkg::CKSRE_CYC;
  logic sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp, cke, term;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic dll_en, locked, ready, ign, sref, pdn;
  dmccs_pkg::dmccs_cmd_t cmd;
  logic [31:0] mdl [0:15];
  int err_count, cmp_count, seed;
  assign hready = hreadyout;
  dmccs_seq u_dmccs_seq (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cmd(cmd), .cke(cke),
    .term_ctrl_in(term), .dll_enabled(dll_en), .dll_locked(locked),
    .cmd_ready(ready), .clock_ignored(ign), .self_refresh(sref),
    .power_down(pdn));
  dmccs_ctrl u_dmccs_ctrl (.sys_clk(sys_clk), .cmd(cmd), .cke(cke),
    .term_ctrl_in(term));
  // Free running 125 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Single word transfer: address phase, then data phase.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin @(posedge sys_clk); n++; end
      while (hready !== 1'b1 && n < 20);
      if (n >= 20) begin err_count++; end_sim(); end
      htrans <= 2'h0;
      hwdata <= d;
    end
    rd = hrdata;
  endtask
  task rdm(input int i);
    bus(1'b0, 8'(i * 4), 32'h0);
    chk("reg", rd, mdl[i]);
  endtask
  task op(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a,
          input logic k);
    u_dmccs_ctrl.op(c, b, a, k);
  endtask
  // Self refresh entry and exit, checking the clock is ignored inside.
  task sr;
    op(4'h1, 3'h0, 13'h0000, 1'b0);
    tick(SRE + 2);
    chk("sref", {sref, ign}, 2'h3);
    op(4'h7, 3'h0, 13'h0000, 1'b1);
    tick(XS + 2);
  endtask
  // Watchdog cuts a hang short.
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    end_sim();
  end
  // Main sequence.
  initial begin
    seed = 32'hB98C;
    {rst, hsel, htrans, hwrite, hsize} = {1'b1, 4'h0, 3'h2};
    {haddr, hwdata, err_count, cmp_count} = '0;
    for (int i = 0; i < 16; i++) mdl[i] = 32'h0;
    mdl[2] = dmccs_pkg::TIME0_RST;
    mdl[3] = dmccs_pkg::TIME1_RST;
    mdl[4] = dmccs_pkg::TIME2_RST;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    tick(2);
    for (int i = 2; i < 9; i += 2) rdm(i);
    mdl[3] = 32'h000A0014;
    mdl[4] = {1'b1, 23'h000000, 8'($random(seed))} | 32'h00000010;
    for (int i = 3; i < 5; i++) bus(1'b1, 8'(i * 4), mdl[i]);
    for (int i = 3; i < 5; i++) rdm(i);
    bus(1'b0, 8'h00, 32'h0);
    chk("status", rd & 32'h3F, 32'h38);
    $display("registers done");
    op(4'h0, 3'h1, 13'h0001, 1'b1);
    chk("off", {ready, dll_en, locked}, 3'h0);
    tick(MOD);
    sr();
    op(4'h0, 3'h0, 13'h0020, 1'b1);
    tick(dmccs_pkg::MRD_CYC + 1);
    op(4'h0, 3'h2, 13'h0008, 1'b1);
    tick(MOD + 1);
    chk("ready", ready, 1'b1);
    rdm(1);
    $display("dll off done");
    sr();
    op(4'h0, 3'h1, 13'h0000, 1'b1);
    chk("on", dll_en, 1'b1);
    tick(dmccs_pkg::MRD_CYC + 1);
    op(4'h0, 3'h0, 13'h0120, 1'b1);
    chk("lock", locked, 1'b0);
    tick(LK + 3);
    chk("lock", locked, 1'b1);
    rdm(1);
    $display("dll on done");
    op(4'h7, 3'h0, 13'h0000, 1'b0);
    tick(SRE + 2);
    chk("pdn", {pdn, ign}, 2'h3);
    op(4'h7, 3'h0, 13'h0000, 1'b1);
    tick(dmccs_pkg::XP_CYC + 2);
    chk("ready", ready, 1'b1);
    chk("relock", locked, 1'b0);
    op(4'h0, 3'h0, 13'h0120, 1'b1);
    tick(LK + 3);
    chk("relock", locked, 1'b1);
    $display("power down done");
    op(4'h0, 3'h1, 13'h0000, 1'b1);
    op(4'h5, 3'h0, 13'h0000, 1'b1);
    bus(1'b0, 8'h04, 32'h0);
    chk("error", rd & 32'h7F, 32'h02);
    bus(1'b1, 8'h04, 32'h0000007F);
    tick(MOD);
    rdm(1);
    op(4'h6, 3'h0, 13'h0400, 1'b1);
    op(4'h5, 3'h0, 13'h0000, 1'b1);
    bus(1'b0, 8'h04, 32'h0);
    chk("error", rd & 32'h7F, 32'h20);
    $display("errors done");
    end_sim();
  end
endmodule // testbench
